// File: dv/sbc_pin_partner.sv
// model of the external reset, standby and nmi circuitry
`default_nettype none
module sbc_pin_partner #(
	parameter int         osc_wait = 800000,
	parameter logic [2:0] mode_val = 3'h7
) (
	input  wire logic       ref_clk,
	input  wire logic       hw_req,
	input  wire logic       nmi_req,
	output logic            reset_pin_n,
	output logic            hw_standby_pin_n,
	output logic            nmi_pin,
	output logic [2:0]      mode_select_pins
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		reset_pin_n = 1'b1;
		hw_standby_pin_n = 1'b1;
	end
	assign mode_select_pins = mode_val;
	assign nmi_pin = nmi_req;
	always @(posedge hw_req) begin
		reset_pin_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		hw_standby_pin_n <= 1'b0;
	end
	always @(negedge hw_req) begin
		hw_standby_pin_n <= 1'b1;
		repeat (osc_wait) @(posedge ref_clk);
		reset_pin_n <= 1'b1;
	end
endmodule
`default_nettype wire

// File: dv/sbc_standby_ctrl_test.sv
// self-checking bench for the standby and clock output controller
`default_nettype none
module sbc_standby_ctrl_test;
	timeunit 1ns;
	timeprecision 1ns;
	import sbc_pkg::*;
	localparam int SB = 4;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic        clk_en = 1'b1;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic        sleep_req = 1'b0;
	logic        bus_cycle_end = 1'b0;
	logic        sys_clk_phase = 1'b0;
	logic        hw_req = 1'b0;
	logic        nmi_req = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [7:0]  port_out_in = 8'h00;
	logic [23:0] addr_in = 24'h0;
	logic [31:0] hrdata, rd;
	logic        hreadyout, hresp, reset_pin_n, hw_standby_pin_n, nmi_pin;
	logic        bus_oe_n, clk_pin_o, clk_pin_oe_n, func_reset, cpu_run;
	logic        osc_en, reset_exception, ram_access_en;
	logic [2:0]  mode_select_pins;
	logic [7:0]  port_out, port_oe_n;
	logic [23:0] addr_out;
	int          error_cnt = 0;
	int          checked = 0;
	int          cyc = 0;
	int          n, nw;
	logic [7:0]  ofs [6] = '{SYS_CTRL_OFS, HW_STANDBY_PIN_N_CTRL_OFS, CLK_CTRL_OFS,
		CLK_DIR_OFS, STATUS_OFS, 8'h40};
	logic [31:0] rv [6] = '{32'h1, 32'h8, 32'h0, 32'h0, 32'h70, 32'h0};
	sbc_pin_partner #(.osc_wait(20)) i_sbc_pin_partner (.ref_clk, .hw_req,
		.nmi_req, .reset_pin_n, .hw_standby_pin_n, .nmi_pin,
		.mode_select_pins);
	sbc_standby_ctrl #(.settle_base(SB)) i_sbc_standby_ctrl (.ref_clk, .rst,
		.clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize(HSIZE_WORD),
		.hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
		.reset_pin_n, .hw_standby_pin_n, .nmi_pin, .irq_any(1'b0),
		.mode_select_pins, .sleep_req, .bus_cycle_end, .sys_clk_phase,
		.port_out_in, .port_oe_n_in(8'h00), .addr_in, .bus_ctrl_in(4'h0),
		.port_out, .port_oe_n, .addr_out, .bus_ctrl_out(), .bus_oe_n,
		.clk_pin_o, .clk_pin_oe_n, .func_reset, .cpu_run, .module_clk_en(),
		.osc_en, .serial_adc_reset(), .ram_access_en, .reset_exception,
		.nmi_taken(), .mode_latched());
	initial forever #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		sys_clk_phase <= ~sys_clk_phase;
		bus_cycle_end <= (cyc[1:0] == 2'h3);
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			error_cnt++;
			close_out();
		end
	end
	task automatic tick(input int k);
		repeat (k) @(posedge ref_clk);
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e,
		input string m);
		checked++;
		if (s !== e) begin
			error_cnt++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	task automatic ahb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic sleep_pulse();
		sleep_req <= 1'b1;
		tick(1);
		sleep_req <= 1'b0;
		tick(2);
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		tick(3);
		rst <= 1'b0;
		tick(4);
		foreach (ofs[i]) begin
			ahb(1'b0, ofs[i], 32'h0);
			chk(rd, rv[i], "reset value");
		end
		$display("test reset done");
		chk(clk_pin_oe_n, 1'b1, "clock pin not input");
		ahb(1'b1, CLK_DIR_OFS, 32'h1);
		tick(2);
		chk(clk_pin_oe_n, 1'b0, "clock pin not driven");
		chk(clk_pin_o, !sys_clk_phase, "clock not output");
		ahb(1'b1, CLK_CTRL_OFS, 32'h8);
		tick(6);
		chk(clk_pin_o, 1'b1, "clock not stopped");
		ahb(1'b1, CLK_CTRL_OFS, 32'h0);
		tick(6);
		chk(clk_pin_o, !sys_clk_phase, "clock not resumed");
		clk_en <= 1'b0;
		tick(1);
		nw = clk_pin_o;
		tick(3);
		chk(clk_pin_o, nw, "clock pin not frozen");
		clk_en <= 1'b1;
		$display("test clock pin done");
		for (int e = 0; e < 2; e++) begin
			nw = e ? SETTLE_SHORT_STATES : SB << 1;
			nmi_req <= e[0];
			ahb(1'b1, SYS_CTRL_OFS, {29'h0, e[0], 2'h1});
			ahb(1'b1, HW_STANDBY_PIN_N_CTRL_OFS, {24'h0, 1'b1, e ? 3'h7 : 3'h1, e[0],
				3'h0});
			port_out_in <= 8'hA5;
			addr_in <= 24'h123456;
			tick(2);
			sleep_pulse();
			port_out_in <= 8'h5A;
			addr_in <= 24'h0;
			nmi_req <= !e[0];
			tick(4);
			chk(osc_en, 1'b0, "woke on wrong edge");
			chk(port_out, 8'hA5, "port not held");
			chk(addr_out, 24'h123456, "address not held");
			chk(bus_oe_n, !e[0], "bus hold wrong");
			chk(clk_pin_o, 1'b1, "clock pin not high");
			nmi_req <= e[0];
			n = 0;
			while (cpu_run !== 1'b1 && n < 200) begin
				tick(1);
				n++;
			end
			chk(n >= nw && n <= nw + 5, 1'b1, "settle wait");
		end
		$display("test software standby done");
		ahb(1'b1, HW_STANDBY_PIN_N_CTRL_OFS, 32'h8);
		ahb(1'b1, SYS_CTRL_OFS, 32'h0);
		sleep_pulse();
		chk(cpu_run | !osc_en, 1'b0, "sleep not entered");
		chk(ram_access_en, 1'b0, "RAM still enabled");
		hw_req <= 1'b1;
		tick(6);
		chk(port_oe_n, 8'hFF, "ports driven");
		chk(clk_pin_oe_n & bus_oe_n & func_reset, 1'b1, "not off");
		hw_req <= 1'b0;
		tick(3);
		chk(func_reset & osc_en, 1'b1, "no reset hold");
		n = 0;
		while (reset_exception !== 1'b1 && n < 100) begin
			tick(1);
			n++;
		end
		chk(reset_exception & cpu_run, 1'b1, "no reset exit");
		ahb(1'b0, SYS_CTRL_OFS, 32'h0);
		chk(rd, 32'h1, "control not reset");
		$display("test hardware standby done");
		close_out();
	end
endmodule
`default_nettype wire

// File: dv/sbc_standby_monitor.sv
// concurrent checks on the standby controller ports
`default_nettype none
module sbc_standby_monitor #(
	parameter int settle_base = 4
) (
	input wire logic       ref_clk,
	input wire logic       rst,
	input wire logic       clk_en,
	input wire logic       reset_pin_n,
	input wire logic       hw_standby_pin_n,
	input wire logic       sleep_req,
	input wire logic [7:0] port_out,
	input wire logic [7:0] port_oe_n,
	input wire logic       bus_oe_n,
	input wire logic       clk_pin_o,
	input wire logic       clk_pin_oe_n,
	input wire logic       func_reset,
	input wire logic       cpu_run,
	input wire logic       module_clk_en,
	input wire logic       osc_en,
	input wire logic       serial_adc_reset,
	input wire logic       reset_exception,
	input wire logic       nmi_taken
);
	wire sw_hw_standby_pin_n = !osc_en && !func_reset;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	sequence s_exc;
		!func_reset ##1 (cpu_run && reset_exception) ##1 !reset_exception;
	endsequence
	sequence s_wait_done;
		(!module_clk_en && osc_en && !func_reset) ##1 cpu_run;
	endsequence
	chk_hw_enter:
	assert property (clk_en && !hw_standby_pin_n |=> port_oe_n == 8'hFF
		&& bus_oe_n && clk_pin_oe_n) else $error("pins driven in hw standby");
	chk_hw_reset:
	assert property ($past(clk_en && !hw_standby_pin_n) |-> func_reset
		&& !osc_en && serial_adc_reset) else $error("hw standby not reset");
	chk_hw_exit:
	assert property (clk_en && $past(!hw_standby_pin_n) && hw_standby_pin_n
		&& !reset_pin_n |=> func_reset && osc_en) else $error("no reset hold");
	chk_rst_exc:
	assert property (clk_en && func_reset && osc_en && reset_pin_n
		&& hw_standby_pin_n |=> s_exc) else $error("reset exit wrong");
	chk_sleep_go:
	assert property (clk_en && sleep_req && cpu_run && reset_pin_n
		&& hw_standby_pin_n |=> !cpu_run) else $error("sleep ignored");
	chk_sw_stop:
	assert property (sw_hw_standby_pin_n |-> serial_adc_reset && !module_clk_en
		&& !cpu_run) else $error("standby not stopped");
	chk_port_hold:
	assert property (sw_hw_standby_pin_n && $past(sw_hw_standby_pin_n) |-> $stable(port_out)
		&& $stable(port_oe_n)) else $error("ports moved in standby");
	chk_clk_high:
	assert property (sw_hw_standby_pin_n && $past(sw_hw_standby_pin_n) |-> clk_pin_o)
		else $error("clock pin not high");
	chk_wake_pulse:
	assert property (s_wait_done |-> ##[0:2] nmi_taken)
		else $error("no wake pulse");
endmodule
bind sbc_standby_ctrl sbc_standby_monitor #(.settle_base(settle_base))
	i_sbc_standby_monitor (.ref_clk, .rst, .clk_en, .reset_pin_n,
	.hw_standby_pin_n, .sleep_req, .port_out, .port_oe_n, .bus_oe_n,
	.clk_pin_o, .clk_pin_oe_n, .func_reset, .cpu_run, .module_clk_en,
	.osc_en, .serial_adc_reset, .reset_exception, .nmi_taken);
`default_nettype wire

// File: hdl/sbc_pkg.sv
// constants, types and register map of the standby and clock output block
// What this block does
// - nmi_edge_select picks falling (0) or rising (1)
// - sleep with standby_select set enters software standby
// - software standby holds ports; optionally bus outputs
// - hardware standby pin low overrides every state
// - hardware standby: reset, stopped, ports high impedance
// - standby release under reset restarts oscillator
// - reset rise runs reset exception, then program
// - clk_out_stop halts clock pin high at cycle end
// - direction bit 0 makes clock pin an input
// - clock pin state follows processing state table
// - software standby stops clocks; serial, ADC reset
// - waking interrupt waits selected settle count
`default_nettype none
package sbc_pkg;
	localparam logic [7:0] SYS_CTRL_OFS   = 8'h00;
	localparam logic [7:0] HW_STANDBY_PIN_N_CTRL_OFS  = 8'h04;
	localparam logic [7:0] CLK_CTRL_OFS   = 8'h08;
	localparam logic [7:0] CLK_DIR_OFS    = 8'h0C;
	localparam logic [7:0] STATUS_OFS     = 8'h10;

	localparam int RAM_EN_BIT     = 0;
	localparam int NMI_EDGE_BIT   = 2;
	localparam int HW_STANDBY_PIN_N_SEL_BIT   = 7;
	localparam int SETTLE_LSB     = 4;
	localparam int OUT_HOLD_BIT   = 3;
	localparam int CLK_STOP_BIT   = 3;
	localparam int CLK_DIR_BIT    = 0;

	localparam logic RAM_EN_RST   = 1'b1;
	localparam logic NMI_EDGE_RST = 1'b0;
	localparam logic HW_STANDBY_PIN_N_SEL_RST = 1'b0;
	localparam logic OUT_HOLD_RST = 1'b1;
	localparam logic CLK_STOP_RST = 1'b0;
	localparam logic CLK_DIR_RST  = 1'b0;
	localparam logic [2:0] SETTLE_RST = 3'h0;

	localparam int SETTLE_W            = 19;
	localparam int SETTLE_BASE_STATES  = 8192;
	localparam int SETTLE_SHORT_STATES = 16;
	localparam logic [2:0] SETTLE_SEL_RESV  = 3'h6;
	localparam logic [2:0] SETTLE_SEL_SHORT = 3'h7;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD    = 3'h2;

	typedef enum logic [2:0] {
		SBC_RUN,
		SBC_SLEEP,
		SBC_SW_HW_STANDBY_PIN_N,
		SBC_OSC_WAIT,
		SBC_HW_HW_STANDBY_PIN_N,
		SBC_RST_HOLD,
		SBC_RST_EXC
	} sbc_state_e;
endpackage
`default_nettype wire

// File: hdl/sbc_settle_if.sv
// start, select and done between the controller and its settle timer
`default_nettype none
interface sbc_settle_if;
	logic       start;
	logic [2:0] sel;
	logic       done;
	modport ctrl (output start, output sel, input done);
	modport tmr  (input start, input sel, output done);
endinterface
`default_nettype wire

// File: hdl/sbc_settle_timer.sv
// oscillator settle wait counter with selectable length
`default_nettype none
module sbc_settle_timer #(
	parameter int settle_base = sbc_pkg::SETTLE_BASE_STATES
) (
	input  wire logic   ref_clk,
	input  wire logic   rst,
	input  wire logic   clk_en,
	sbc_settle_if.tmr   st
);
	import sbc_pkg::*;

	logic [SETTLE_W-1:0] count;
	logic [SETTLE_W-1:0] target;
	logic                busy;
	logic                done_q;

	// reserved code falls back to the longest wait
	always_comb begin
		if (st.sel == SETTLE_SEL_SHORT) begin
			target = SETTLE_W'(SETTLE_SHORT_STATES);
		end else if (st.sel == SETTLE_SEL_RESV) begin
			target = SETTLE_W'(settle_base) << 5;
		end else begin
			target = SETTLE_W'(settle_base) << st.sel;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			count  <= '0;
			busy   <= 1'b0;
			done_q <= 1'b0;
		end else if (clk_en) begin
			done_q <= 1'b0;
			if (st.start) begin
				count <= target - SETTLE_W'(1);
				busy  <= 1'b1;
			end else if (busy) begin
				if (count == '0) begin
					busy   <= 1'b0;
					done_q <= 1'b1;
				end else begin
					count <= count - SETTLE_W'(1);
				end
			end
		end
	end

	assign st.done = done_q;
endmodule
`default_nettype wire

// File: hdl/sbc_standby_ctrl.sv
// standby sequencing, clock pin gating and register slave
//
// Chosen here: the AHB-Lite interface to the registers and the register offsets.
`default_nettype none
module sbc_standby_ctrl #(
	parameter int settle_base = sbc_pkg::SETTLE_BASE_STATES
) (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        clk_en,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        reset_pin_n,
	input  wire logic        hw_standby_pin_n,
	input  wire logic        nmi_pin,
	input  wire logic        irq_any,
	input  wire logic [2:0]  mode_select_pins,
	input  wire logic        sleep_req,
	input  wire logic        bus_cycle_end,
	input  wire logic        sys_clk_phase,
	input  wire logic [7:0]  port_out_in,
	input  wire logic [7:0]  port_oe_n_in,
	input  wire logic [23:0] addr_in,
	input  wire logic [3:0]  bus_ctrl_in,
	output logic [7:0]       port_out,
	output logic [7:0]       port_oe_n,
	output logic [23:0]      addr_out,
	output logic [3:0]       bus_ctrl_out,
	output logic             bus_oe_n,
	output logic             clk_pin_o,
	output logic             clk_pin_oe_n,
	output logic             func_reset,
	output logic             cpu_run,
	output logic             module_clk_en,
	output logic             osc_en,
	output logic             serial_adc_reset,
	output logic             ram_access_en,
	output logic             reset_exception,
	output logic             nmi_taken,
	output logic [2:0]       mode_latched
);
	import sbc_pkg::*;

	sbc_state_e state;
	sbc_state_e next_state;

	logic       onchip_ram_enable;
	logic       nmi_edge_select;
	logic       standby_select;
	logic       output_hold_enable;
	logic [2:0] settle_time_select;
	logic       clk_out_stop;
	logic       clk_pin_dir;
	logic       clk_stop_eff;

	logic       nmi_q;
	logic       nmi_edge;
	logic       hw_hw_standby_pin_n;
	logic       sw_hw_standby_pin_n;

	logic       dp_write;
	logic [7:0] dp_addr;
	logic       ap_take;
	logic [31:0] read_mux;

	sbc_settle_if st ();

	sbc_settle_timer #(
		.settle_base(settle_base)
	) u_settle (
		.ref_clk(ref_clk),
		.rst    (rst),
		.clk_en (clk_en),
		.st     (st)
	);

	assign hw_hw_standby_pin_n = (state == SBC_HW_HW_STANDBY_PIN_N);
	assign sw_hw_standby_pin_n = (state == SBC_SW_HW_STANDBY_PIN_N) || (state == SBC_OSC_WAIT);

	// register slave: zero wait, always OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign ap_take   = hsel && hready && (htrans == HTRANS_NONSEQ);

	always_comb begin
		read_mux = 32'h0000_0000;
		unique case (haddr[7:0])
			SYS_CTRL_OFS: begin
				read_mux[RAM_EN_BIT]   = onchip_ram_enable;
				read_mux[NMI_EDGE_BIT] = nmi_edge_select;
			end
			HW_STANDBY_PIN_N_CTRL_OFS: begin
				read_mux[HW_STANDBY_PIN_N_SEL_BIT] = standby_select;
				read_mux[OUT_HOLD_BIT] = output_hold_enable;
				read_mux[SETTLE_LSB +: 3] = settle_time_select;
			end
			CLK_CTRL_OFS: begin
				read_mux[CLK_STOP_BIT] = clk_out_stop;
			end
			CLK_DIR_OFS: begin
				read_mux[CLK_DIR_BIT] = clk_pin_dir;
			end
			STATUS_OFS: begin
				read_mux[2:0] = 3'(state);
				read_mux[3]   = clk_stop_eff;
				read_mux[6:4] = mode_latched;
			end
			default: begin
				read_mux = 32'h0000_0000;
			end
		endcase
		if (haddr[31:8] != 24'h00_0000) begin
			read_mux = 32'h0000_0000;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			dp_write <= 1'b0;
			dp_addr  <= 8'h00;
			hrdata   <= 32'h0000_0000;
		end else if (clk_en) begin
			dp_write <= ap_take && hwrite && (hsize == HSIZE_WORD)
				&& (haddr[31:8] == 24'h00_0000);
			if (ap_take) begin
				dp_addr <= haddr[7:0];
			end
			if (ap_take && !hwrite) begin
				hrdata <= read_mux;
			end
		end
	end

	// hardware standby returns every control bit to reset
	always_ff @(posedge ref_clk) begin
		if (rst || hw_hw_standby_pin_n) begin
			onchip_ram_enable  <= RAM_EN_RST;
			nmi_edge_select    <= NMI_EDGE_RST;
			standby_select     <= HW_STANDBY_PIN_N_SEL_RST;
			output_hold_enable <= OUT_HOLD_RST;
			settle_time_select <= SETTLE_RST;
			clk_out_stop       <= CLK_STOP_RST;
			clk_pin_dir        <= CLK_DIR_RST;
		end else if (clk_en && dp_write) begin
			unique case (dp_addr)
				SYS_CTRL_OFS: begin
					onchip_ram_enable <= hwdata[RAM_EN_BIT];
					nmi_edge_select   <= hwdata[NMI_EDGE_BIT];
				end
				HW_STANDBY_PIN_N_CTRL_OFS: begin
					standby_select     <= hwdata[HW_STANDBY_PIN_N_SEL_BIT];
					output_hold_enable <= hwdata[OUT_HOLD_BIT];
					settle_time_select <= hwdata[SETTLE_LSB +: 3];
				end
				CLK_CTRL_OFS: begin
					clk_out_stop <= hwdata[CLK_STOP_BIT];
				end
				CLK_DIR_OFS: begin
					clk_pin_dir <= hwdata[CLK_DIR_BIT];
				end
				default: begin
				end
			endcase
		end
	end

	// nmi edge of the programmed polarity
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			nmi_q <= 1'b0;
		end else if (clk_en) begin
			nmi_q <= nmi_pin;
		end
	end

	assign nmi_edge = nmi_edge_select ? (nmi_pin && !nmi_q)
		: (!nmi_pin && nmi_q);

	always_comb begin
		next_state = state;
		unique case (state)
			SBC_RUN: begin
				if (sleep_req) begin
					next_state = standby_select ? SBC_SW_HW_STANDBY_PIN_N
						: SBC_SLEEP;
				end
			end
			SBC_SLEEP: begin
				if (irq_any || nmi_edge) begin
					next_state = SBC_RUN;
				end
			end
			SBC_SW_HW_STANDBY_PIN_N: begin
				if (nmi_edge) begin
					next_state = SBC_OSC_WAIT;
				end
			end
			SBC_OSC_WAIT: begin
				if (st.done) begin
					next_state = SBC_RUN;
				end
			end
			SBC_HW_HW_STANDBY_PIN_N: begin
				next_state = SBC_RST_HOLD;
			end
			SBC_RST_HOLD: begin
				if (reset_pin_n) begin
					next_state = SBC_RST_EXC;
				end
			end
			SBC_RST_EXC: begin
				next_state = SBC_RUN;
			end
		endcase
		if (!reset_pin_n && state != SBC_HW_HW_STANDBY_PIN_N) begin
			next_state = SBC_RST_HOLD;
		end
		if (!hw_standby_pin_n) begin
			next_state = SBC_HW_HW_STANDBY_PIN_N;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state <= SBC_RST_HOLD;
		end else if (clk_en) begin
			state <= next_state;
		end
	end

	assign st.start = (state == SBC_SW_HW_STANDBY_PIN_N)
		&& (next_state == SBC_OSC_WAIT);
	assign st.sel   = settle_time_select;

	// stop request takes effect only at a bus cycle boundary
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			clk_stop_eff <= CLK_STOP_RST;
		end else if (clk_en && bus_cycle_end) begin
			clk_stop_eff <= clk_out_stop;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			clk_pin_o    <= 1'b1;
			clk_pin_oe_n <= 1'b1;
		end else if (clk_en) begin
			clk_pin_oe_n <= !clk_pin_dir || hw_hw_standby_pin_n
				|| !hw_standby_pin_n;
			if (sw_hw_standby_pin_n || clk_stop_eff) begin
				clk_pin_o <= 1'b1;
			end else begin
				clk_pin_o <= sys_clk_phase;
			end
		end
	end

	// ports keep their last drive through software standby
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			port_out  <= 8'h00;
			port_oe_n <= 8'hFF;
		end else if (clk_en) begin
			if (!hw_standby_pin_n || hw_hw_standby_pin_n) begin
				port_oe_n <= 8'hFF;
			end else if (!sw_hw_standby_pin_n && next_state != SBC_SW_HW_STANDBY_PIN_N) begin
				port_out  <= port_out_in;
				port_oe_n <= port_oe_n_in;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			addr_out     <= 24'h00_0000;
			bus_ctrl_out <= 4'hF;
			bus_oe_n     <= 1'b1;
		end else if (clk_en) begin
			if (hw_hw_standby_pin_n || !hw_standby_pin_n) begin
				bus_oe_n <= 1'b1;
			end else if (sw_hw_standby_pin_n) begin
				bus_oe_n <= !output_hold_enable;
			end else begin
				addr_out     <= addr_in;
				bus_ctrl_out <= bus_ctrl_in;
				bus_oe_n     <= 1'b0;
			end
		end
	end

	// mode pins are sampled while the core is held in reset
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mode_latched <= 3'h0;
		end else if (clk_en && state == SBC_RST_HOLD) begin
			mode_latched <= mode_select_pins;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			reset_exception <= 1'b0;
			nmi_taken       <= 1'b0;
		end else if (clk_en) begin
			reset_exception <= (state == SBC_RST_EXC);
			nmi_taken <= ((state == SBC_OSC_WAIT) && st.done)
				|| ((state == SBC_RUN || state == SBC_SLEEP)
				&& nmi_edge && hw_standby_pin_n && reset_pin_n);
		end
	end

	assign func_reset       = hw_hw_standby_pin_n || (state == SBC_RST_HOLD);
	assign cpu_run          = (state == SBC_RUN);
	assign module_clk_en    = !sw_hw_standby_pin_n && !hw_hw_standby_pin_n;
	assign osc_en           = (state != SBC_SW_HW_STANDBY_PIN_N) && !hw_hw_standby_pin_n;
	assign serial_adc_reset = sw_hw_standby_pin_n || hw_hw_standby_pin_n;
	assign ram_access_en    = onchip_ram_enable && !hw_hw_standby_pin_n;
endmodule
`default_nettype wire
